/* File: pkg/fmd_pkg.sv */
// Constants, register layouts and modes of the freefall/motion event detector.
// Assumes one clock domain; samples arrive as one-cycle strobes at the data rate.
package fmd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FMD_ADDR_CFG = 8'h15;
  localparam logic [7:0] FMD_ADDR_SRC = 8'h16;
  localparam logic [7:0] FMD_ADDR_THS = 8'h17;
  localparam logic [7:0] FMD_ADDR_CNT = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] FMD_CFG_RESET = 8'h00;
  localparam logic [7:0] FMD_THS_RESET = 8'h00;
  localparam logic [7:0] FMD_CNT_RESET = 8'h00;
  localparam logic [7:0] FMD_SRC_RESET = 8'h00;
  localparam logic [7:0] FMD_RDATA_RESET = 8'h00;
  localparam logic [7:0] FMD_DBC_ZERO = 8'h00;
  localparam logic [7:0] FMD_DBC_STEP = 8'h01;
  localparam logic [2:0] FMD_CFG_UNUSED = 3'h0;
  localparam int FMD_AXES = 3;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic event_latch_enable;
    logic or_and_combination_select;
    logic z_axis_event_enable;
    logic y_axis_event_enable;
    logic x_axis_event_enable;
    logic [2:0] unused;
  } fmd_cfg_t;

  typedef struct packed {
    logic debounce_decrement_or_clear_mode;
    logic [6:0] threshold;
  } fmd_ths_t;

  typedef struct packed {
    logic event_active_flag;
    logic reserved;
    logic z_high_event_flag;
    logic z_event_polarity;
    logic y_high_event_flag;
    logic y_event_polarity;
    logic x_high_event_flag;
    logic x_event_polarity;
  } fmd_src_t;

  // Axis 2 is Z, 1 is Y, 0 is X; two's complement per axis
  typedef struct packed {
    logic [2:0][7:0] axis;
  } fmd_sample_t;

  // Order follows {combination select, latch enable}
  typedef enum logic [1:0] {
    FMD_FF_LIVE,
    FMD_FF_LATCH,
    FMD_MT_LIVE,
    FMD_MT_LATCH
  } fmd_mode_t;

endpackage

/* File: hdl/fmd_axis_cmp.sv */
// One axis comparator: magnitude against the shared 7-bit threshold.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module fmd_axis_cmp (
  // Sample and setup
  input wire logic [7:0] sample_in,
  input wire logic [6:0] threshold_in,
  input wire logic enable_in,
  // Result
  output logic high_out,
  output logic negative_out
);
  logic [7:0] magnitude;

  // -128 maps to 8'h80, still a correct unsigned magnitude
  assign magnitude = sample_in[7] ? 8'(-sample_in) : sample_in;

  // strictly above is high, else low
  assign high_out = enable_in && (magnitude > {1'b0, threshold_in});
  assign negative_out = enable_in && sample_in[7];
endmodule // fmd_axis_cmp

/* File: hdl/fmd_detector.sv */
// Freefall/motion event detector with its four register map entries.
// Assumes the register port and the sample strobe share clk_sys_in.
`timescale 1ns/1ps
module fmd_detector (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Samples at the output data rate
  input wire logic sample_valid_in,
  input wire fmd_pkg::fmd_sample_t sample_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Event state
  output logic event_active_out,
  output fmd_pkg::fmd_src_t event_source_out
);
  import fmd_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  fmd_cfg_t cfg;
  fmd_ths_t ths;
  logic [7:0] dbc_target;
  logic [7:0] dbc;
  logic ea;
  logic [5:0] flags;
  logic [7:0] rdata;

  logic [2:0] axis_en;
  logic [2:0] axis_high;
  logic [2:0] axis_neg;
  logic [5:0] live_flags;
  logic any_en;
  logic latched;
  logic motion;
  logic cond;
  logic src_read;
  logic rd_clear;
  fmd_mode_t mode;
  fmd_src_t src_now;
  logic [7:0] dbc_base;
  logic ea_base;
  logic [5:0] flags_base;
  logic [7:0] next_dbc;
  logic next_ea;
  logic [5:0] next_flags;

  // ----------------------------------------------------------------
  // Axis comparison
  // ----------------------------------------------------------------
  // disabled axes report neither high nor polarity
  assign axis_en = {cfg.z_axis_event_enable, cfg.y_axis_event_enable,
                    cfg.x_axis_event_enable};

  genvar gi;
  generate
    for (gi = 0; gi < FMD_AXES; gi++) begin : g_axis
      fmd_axis_cmp u_cmp (
        .sample_in(sample_in.axis[gi]),
        .threshold_in(ths.threshold),
        .enable_in(axis_en[gi]),
        .high_out(axis_high[gi]),
        .negative_out(axis_neg[gi])
      );
      assign live_flags[2*gi+1] = axis_high[gi];
      assign live_flags[2*gi] = axis_neg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Mode and combined condition
  // ----------------------------------------------------------------
  // no enabled axis means no detection at all
  assign any_en = |axis_en;
  // mode from the two config bits
  assign mode = fmd_mode_t'({cfg.or_and_combination_select, cfg.event_latch_enable});
  assign src_read = reg_rd_in && (reg_addr_in == FMD_ADDR_SRC);

  always_comb begin
    latched = 1'b0;
    motion = 1'b0;
    case (mode)
      FMD_FF_LIVE: begin
        latched = 1'b0;
        motion = 1'b0;
      end
      FMD_FF_LATCH: begin
        latched = 1'b1;
        motion = 1'b0;
      end
      FMD_MT_LIVE: begin
        latched = 1'b0;
        motion = 1'b1;
      end
      FMD_MT_LATCH: begin
        latched = 1'b1;
        motion = 1'b1;
      end
      default: begin
        latched = 1'b0;
        motion = 1'b0;
      end
    endcase
  end

  // freefall needs every enabled axis low, motion any enabled high
  assign cond = motion ? |(axis_high & axis_en) : (any_en && &(~axis_high | ~axis_en));

  // reads only clear anything in the latched modes
  assign rd_clear = src_read && latched;

  assign src_now = '{event_active_flag: ea, reserved: 1'b0,
                     z_high_event_flag: flags[5], z_event_polarity: flags[4],
                     y_high_event_flag: flags[3], y_event_polarity: flags[2],
                     x_high_event_flag: flags[1], x_event_polarity: flags[0]};

  // ----------------------------------------------------------------
  // Debounce and event-active flag
  // ----------------------------------------------------------------
  // A read clear applies first; a sample in the same cycle counts on from zero
  always_comb begin
    // latched read restarts the count from zero
    dbc_base = rd_clear ? FMD_DBC_ZERO : dbc;
    ea_base = rd_clear ? 1'b0 : ea;
    next_dbc = dbc_base;
    next_ea = ea_base;
    if (!any_en) begin
      next_dbc = FMD_DBC_ZERO;
      next_ea = 1'b0;
    end else if (sample_valid_in) begin
      if (cond) begin
        // one step per sample, saturating at the target
        if (dbc_base < dbc_target) begin
          next_dbc = dbc_base + FMD_DBC_STEP;
        end
        // set when the count reaches its target
        if (next_dbc == dbc_target) begin
          next_ea = 1'b1;
        end
      end else if (ths.debounce_decrement_or_clear_mode) begin
        // clear mode drops at once when not latched
        next_dbc = FMD_DBC_ZERO;
        if (!latched) begin
          next_ea = 1'b0;
        end
      end else begin
        // decrement mode releases only after counting down
        if (dbc_base != FMD_DBC_ZERO) begin
          next_dbc = dbc_base - FMD_DBC_STEP;
        end
        if (!latched && next_dbc == FMD_DBC_ZERO) begin
          next_ea = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      dbc <= FMD_DBC_ZERO;
      ea <= 1'b0;
    end else begin
      dbc <= next_dbc;
      ea <= next_ea;
    end
  end

  // ----------------------------------------------------------------
  // Per-axis flags
  // ----------------------------------------------------------------
  always_comb begin
    // latched motion read wipes the axis flags as well
    flags_base = (rd_clear && motion) ? '0 : flags;
    next_flags = flags_base;
    if (!any_en) begin
      next_flags = '0;
    end else if (sample_valid_in && !(latched && ea_base)) begin
      // track live results unless frozen by a latched event
      next_flags = live_flags;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cfg <= fmd_cfg_t'(FMD_CFG_RESET);
      ths <= fmd_ths_t'(FMD_THS_RESET);
      dbc_target <= FMD_CNT_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        // unused low bits are never stored
        FMD_ADDR_CFG: cfg <= fmd_cfg_t'({reg_wdata_in[7:3], FMD_CFG_UNUSED});
        FMD_ADDR_THS: ths <= fmd_ths_t'(reg_wdata_in);
        FMD_ADDR_CNT: dbc_target <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // data latched from the pre-clear values on the read edge
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rdata <= FMD_RDATA_RESET;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        FMD_ADDR_CFG: rdata <= cfg;
        // source layout with bit 6 reading zero
        FMD_ADDR_SRC: rdata <= src_now;
        FMD_ADDR_THS: rdata <= ths;
        FMD_ADDR_CNT: rdata <= dbc_target;
        default: rdata <= FMD_RDATA_RESET;
      endcase
    end
  end

  assign reg_rdata_out = rdata;
  assign event_active_out = ea;
  assign event_source_out = src_now;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_src_read;
    src_read;
  endsequence

  sequence s_latched_read_idle;
    latched && any_en && src_read && !sample_valid_in;
  endsequence

  chk_read_preclear: assert property (
    s_src_read |=> reg_rdata_out == $past(src_now)
  ) else $error("source read returned post-clear data");

  chk_disabled_idle: assert property (
    !any_en |=> !ea && flags == '0 && dbc == FMD_DBC_ZERO
  ) else $error("disabled detector not idle");

  chk_live_read_inert: assert property (
    !latched && any_en && src_read && !sample_valid_in
      |=> ea == $past(ea) && dbc == $past(dbc) && flags == $past(flags)
  ) else $error("live-mode read changed detector state");

  chk_latch_hold: assert property (
    latched && any_en && ea && !src_read |=> ea
  ) else $error("latched event dropped without a read");

  chk_latch_readclr: assert property (
    s_latched_read_idle ##0 ea |=> !ea && dbc == FMD_DBC_ZERO
  ) else $error("latched read did not clear event and counter");

  chk_motion_readclr: assert property (
    s_latched_read_idle ##0 motion |=> src_now == fmd_src_t'(FMD_SRC_RESET)
  ) else $error("latched motion read left source bits set");

  chk_flags_freeze: assert property (
    latched && any_en && ea && !src_read |=> flags == $past(flags)
  ) else $error("flags moved while latched event pending");

  chk_flags_track: assert property (
    sample_valid_in && !latched && any_en |=> flags == $past(live_flags)
  ) else $error("live flags did not follow the sample");

  chk_clear_mode_drop: assert property (
    !latched && any_en && sample_valid_in && !cond && ths.debounce_decrement_or_clear_mode
      |=> !ea && dbc == FMD_DBC_ZERO
  ) else $error("clear mode did not drop event at once");

  chk_set_on_count: assert property (
    any_en && sample_valid_in && cond && !rd_clear && dbc <= dbc_target
      && dbc_target - dbc <= FMD_DBC_STEP |=> ea
  ) else $error("event not raised at debounce target");

  chk_rise_at_count: assert property (
    $rose(ea) && $stable(dbc_target) |-> dbc == dbc_target
  ) else $error("event raised before full debounce count");

  chk_decr_release: assert property (
    !latched && any_en && sample_valid_in && !cond && !ths.debounce_decrement_or_clear_mode
      && ea && dbc > FMD_DBC_STEP |=> ea && dbc == $past(dbc) - FMD_DBC_STEP
  ) else $error("decrement mode released event before count ran out");

  chk_ff_high_drop: assert property (
    !latched && !motion && any_en && sample_valid_in && ths.debounce_decrement_or_clear_mode
      && (axis_high & axis_en) != '0 |=> !ea
  ) else $error("enabled high axis did not break freefall");

  chk_live_motion_read: assert property (
    !latched && motion && any_en && src_read && !sample_valid_in
      |=> $stable(event_source_out) && $stable(dbc)
  ) else $error("live motion read changed detector state");

  chk_cfg_write: assert property (
    reg_wr_in && reg_addr_in == FMD_ADDR_CFG
      |=> cfg == fmd_cfg_t'($past(reg_wdata_in) & 8'hf8)
  ) else $error("config write stored wrong fields");

  chk_rdata_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out)
  ) else $error("read data moved without a read");
endmodule // fmd_detector

/* File: bench/fmd_host_model.sv */
// Host side model: a byte strobe register master for the detector.
// Assumes the detector takes a strobe at the rising edge and registers its answer on that same edge.
`timescale 1ns/1ps
module fmd_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Register port
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask
endmodule // fmd_host_model

/* File: bench/fmd_detector_tb_top.sv */
// Bench top: host model drives the registers, the bench drives samples.
// Assumes flags settle one cycle after each sample strobe.
`timescale 1ns/1ps
module fmd_detector_tb_top;
  import fmd_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic sample_valid_in = 1'b0;
  fmd_sample_t sample_in = '0;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic [7:0] reg_rdata_out;
  logic reg_wr_in;
  logic reg_rd_in;
  logic event_active_out;
  fmd_src_t event_source_out;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] rv;

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  fmd_host_model i_fmd_host_model (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in),
    .reg_rdata_in(reg_rdata_out));

  fmd_detector i_fmd_detector (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .event_active_out(event_active_out),
    .event_source_out(event_source_out));

  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic smp(input logic [7:0] z, input logic [7:0] y, input logic [7:0] x);
    @(negedge clk_sys_in);
    sample_valid_in = 1'b1;
    sample_in.axis = {z, y, x};
    @(negedge clk_sys_in);
    sample_valid_in = 1'b0;
    @(negedge clk_sys_in);
  endtask

  // Disabling first clears any state left by the previous scenario
  task automatic setup(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n);
    i_fmd_host_model.wr(FMD_ADDR_CFG, 8'h00);
    i_fmd_host_model.wr(FMD_ADDR_CNT, n);
    i_fmd_host_model.wr(FMD_ADDR_THS, t);
    i_fmd_host_model.wr(FMD_ADDR_CFG, c);
  endtask

  task automatic s_regs();
    i_fmd_host_model.rd(FMD_ADDR_CFG, rv);
    chk("cfg reset", 8'h00, rv);
    i_fmd_host_model.rd(FMD_ADDR_SRC, rv);
    chk("src reset", 8'h00, rv);
    i_fmd_host_model.rd(FMD_ADDR_THS, rv);
    chk("ths reset", 8'h00, rv);
    i_fmd_host_model.wr(FMD_ADDR_CFG, 8'hff);
    i_fmd_host_model.rd(FMD_ADDR_CFG, rv);
    chk("cfg fields", 8'hf8, rv);
    i_fmd_host_model.wr(FMD_ADDR_SRC, 8'hff);
    i_fmd_host_model.rd(FMD_ADDR_SRC, rv);
    chk("src read only", 8'h00, rv);
    i_fmd_host_model.rd(8'h20, rv);
    chk("unmapped", 8'h00, rv);
  endtask

  task automatic s_ff_live();
    setup(8'h38, 8'h0a, 8'h02);
    smp(8'h01, 8'h02, 8'h03);
    chk("ff first", 8'h00, {7'h00, event_active_out});
    smp(8'h01, 8'h02, 8'h03);
    chk("ff src", 8'h80, event_source_out);
    i_fmd_host_model.rd(FMD_ADDR_SRC, rv);
    chk("ff read data", 8'h80, rv);
    chk("ff read ea", 8'h01, {7'h00, event_active_out});
    smp(8'h00, 8'h00, 8'h14);
    chk("ff decr one", 8'h82, event_source_out);
    smp(8'h00, 8'h00, 8'h14);
    chk("ff decr two", 8'h02, event_source_out);
  endtask

  task automatic s_ff_clear();
    setup(8'h38, 8'h8a, 8'h02);
    smp(8'h00, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    chk("clr set", 8'h01, {7'h00, event_active_out});
    smp(8'h14, 8'h00, 8'h00);
    chk("clr drop", 8'h00, {7'h00, event_active_out});
    smp(8'h00, 8'h00, 8'h00);
    chk("clr recount", 8'h00, {7'h00, event_active_out});
  endtask

  task automatic s_ff_latch();
    setup(8'hb8, 8'h0a, 8'h02);
    smp(8'h00, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h14);
    chk("ffl hold", 8'h80, event_source_out);
    i_fmd_host_model.rd(FMD_ADDR_SRC, rv);
    chk("ffl read", 8'h80, rv);
    chk("ffl clear", 8'h00, {7'h00, event_active_out});
    smp(8'h00, 8'h00, 8'h00);
    chk("ffl block", 8'h00, {7'h00, event_active_out});
    smp(8'h00, 8'h00, 8'h00);
    chk("ffl again", 8'h01, {7'h00, event_active_out});
  endtask

  task automatic s_mt_latch();
    setup(8'hf8, 8'h0a, 8'h02);
    smp(8'h00, 8'h00, 8'h14);
    smp(8'h00, 8'h00, 8'h14);
    smp(8'hec, 8'h00, 8'h00);
    chk("mtl frozen", 8'h82, event_source_out);
    i_fmd_host_model.rd(FMD_ADDR_SRC, rv);
    chk("mtl read", 8'h82, rv);
    chk("mtl clear", 8'h00, event_source_out);
    smp(8'hec, 8'h00, 8'h00);
    chk("mtl resume", 8'h30, event_source_out);
  endtask

  task automatic s_mt_live();
    setup(8'h48, 8'h8a, 8'h00);
    smp(8'h00, 8'h64, 8'h0a);
    chk("mt boundary", 8'h00, event_source_out);
    smp(8'h00, 8'h00, 8'hf5);
    chk("mt set", 8'h83, event_source_out);
    i_fmd_host_model.rd(FMD_ADDR_SRC, rv);
    chk("mt read data", 8'h83, rv);
    chk("mt read", 8'h83, event_source_out);
    smp(8'h00, 8'h00, 8'h00);
    chk("mt drop", 8'h00, event_source_out);
  endtask

  // A latched event only goes away on disable if the detector really idles
  task automatic s_off();
    setup(8'hb8, 8'h0a, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    chk("off armed", 8'h80, event_source_out);
    i_fmd_host_model.wr(FMD_ADDR_CFG, 8'h80);
    @(negedge clk_sys_in);
    chk("off drop", 8'h00, event_source_out);
    smp(8'h00, 8'h00, 8'h00);
    chk("off src", 8'h00, event_source_out);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    s_regs();
    s_ff_live();
    s_ff_clear();
    s_ff_latch();
    s_mt_latch();
    s_mt_live();
    s_off();
    stop_test();
  end

  // Watchdog bounds the whole run
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule // fmd_detector_tb_top
